/* abu_defs.svh */
// Register offsets, field positions, reset values and step counts
`ifndef ABU_DEFS_SVH
`define ABU_DEFS_SVH
`define ABU_OFF_ACC 8'h00
`define ABU_OFF_CMD 8'h04
`define ABU_OFF_FLAGS 8'h08
`define ABU_OFF_INT_STAT 8'h0C
`define ABU_OFF_INT_CLR 8'h10
`define ABU_OFF_INT_EN 8'h14
`define ABU_CMD_OP_LSB 0
`define ABU_CMD_OP_MSB 3
`define ABU_CMD_CNT_LSB 8
`define ABU_CMD_CNT_MSB 13
`define ABU_FLG_ZERO 0
`define ABU_FLG_NEG 1
`define ABU_FLG_RANGE 2
`define ABU_FLG_BADBCD 3
`define ABU_INT_DONE 0
`define ABU_INT_RANGE 1
`define ABU_INT_BADBCD 2
`define ABU_ACC_RST 32'h0000_0000
`define ABU_INT_EN_RST 3'h0
`define ABU_B2D_STEPS 6'h20
`define ABU_D2B_STEPS 6'h08
`endif

/* abu_pkg.sv */
// Types shared by the accumulator bit operation unit
package abu_pkg;
    typedef enum logic [3:0] {
        ABU_NOP = 4'h0,
        ABU_SHIFT_RIGHT_OP = 4'h1,
        ABU_ROTATE_LEFT_OP = 4'h2,
        ABU_ROTATE_RIGHT_OP = 4'h3,
        ABU_LOWEST_SET_BIT_INDEX_OP = 4'h4,
        ABU_ONE_HOT_EXPAND_OP = 4'h5,
        ABU_BCD_TO_RADIX2_OP = 4'h6,
        ABU_RADIX2_TO_BCD_OP = 4'h7,
        ABU_ONES_COMPLEMENT_OP = 4'h8
    } abu_op_t;
    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_TO_BCD = 2'b01,
        ABU_FROM_BCD = 2'b10
    } abu_state_t;
endpackage

/* abu_seq_model.sv */
// Sequencer model issuing accesses on the register port
`timescale 1ns/100ps
module abu_seq_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [31:0] wr_data,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rd_data
);
    // Idle bus from time zero
    initial begin
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read strobe, data taken in the next cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    // Operation with its count operand
    task automatic cmd(input logic [3:0] op, input logic [5:0] c);
        wr(8'h04, {18'h0, c, 4'h0, op});
    endtask
endmodule

/* abu_unit.sv */
// Accumulator datapath with shift, rotate, encode, decode, BCD and invert
`timescale 1ns/100ps
`include "abu_defs.svh"

// Operation
// - Shift right moves all 32 bits down by the count, 0 to 63.
// - Shift fills vacated bits with zeros; bits shifted out are lost.
// - Rotate left circulates bits upward; bit 31 re-enters at bit 0.
// - Rotate right circulates bits downward; bit 0 re-enters at bit 31.
// - Shift, rotate and both conversions set zero flag on zero result.
// - Same operations set negative flag when result bit 31 is set.
// - Each flag holds until an operation affecting it executes again.
// - Encode gives index of set bit; bit 31 gives 0x1F.
// - Encode of all zeros or only bit 0 yields zero.
// - Several set bits: encode lowest one and set operand-range flag.
// - Decode sets the accumulator bit chosen by a 5-bit index.
// - Decode indexes above 31 use only the low five bits.
// - BCD-to-binary replaces packed BCD with its binary value.
// - BCD-to-binary sets invalid flag when any nibble exceeds nine.
// - Binary-to-BCD replaces the binary value with packed BCD.
// - Invert replaces all 32 bits with their one's complement.
module abu_unit #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic busy,
    output logic zero_result_flag,
    output logic negative_result_flag,
    output logic operand_range_flag,
    output logic invalid_bcd_flag,
    output logic irq
);

    localparam int NIB = 8;

    // Refuse an address too narrow for the map
    // Bits above four are compared to zero, so six bits at least
    generate
        if (ADDR_W < 6) begin : g_chk
            $error("abu_unit: ADDR_W must be at least 6");
        end
    endgenerate

    // Registered state
    logic [31:0] acc_q;
    abu_pkg::abu_state_t state_q;
    logic [5:0] step_q;
    logic [31:0] work_q;
    logic [31:0] src_q;
    logic [2:0] int_stat_q;
    logic [2:0] int_en_q;
    logic [31:0] rd_data_q;
    logic irq_q;
    logic busy_q;
    logic zero_q;
    logic neg_q;
    logic range_q;
    logic badbcd_q;

    // Decode and datapath nets
    logic [7:0] a8;
    logic hit_acc;
    logic hit_cmd;
    logic hit_clr;
    logic hit_en;
    abu_pkg::abu_op_t op;
    logic [5:0] cnt;
    logic start;
    logic [NIB-1:0] nib_bad;
    logic [31:0] dabble_adj;
    logic [31:0] times_ten;
    logic [31:0] acc_next;
    logic acc_load;
    logic flags_zn;
    logic done_ev;
    logic range_ev;
    logic bad_ev;
    logic [2:0] ev;

    // Address decode, widened or cut to the byte offsets
    always_comb begin
        a8 = 8'h00;
        a8[4:0] = addr[4:0];
    end
    assign hit_acc = (a8 == `ABU_OFF_ACC);
    assign hit_cmd = (a8 == `ABU_OFF_CMD);
    assign hit_clr = (a8 == `ABU_OFF_INT_CLR);
    assign hit_en = (a8 == `ABU_OFF_INT_EN);
    assign op = abu_pkg::abu_op_t'(
        wr_data[`ABU_CMD_OP_MSB:`ABU_CMD_OP_LSB]);
    assign cnt = wr_data[`ABU_CMD_CNT_MSB:`ABU_CMD_CNT_LSB];
    // A command is taken only while idle; busy writes are dropped
    assign start = wr_en && hit_cmd && (state_q == abu_pkg::ABU_IDLE)
        && (addr[ADDR_W-1:5] == '0);

    // Rotate left by a count taken modulo 32
    function automatic logic [31:0] rotate_left_op(input logic [31:0] v,
                                         input logic [5:0] n);
        logic [4:0] r;
        r = n[4:0];
        // A zero amount pushes the upper term out whole and gives v
        rotate_left_op = (v << r) | (v >> (6'd32 - {1'b0, r}));
    endfunction

    // Index of the lowest set bit, zero when none
    function automatic logic [31:0] low_index(input logic [31:0] v);
        logic [31:0] idx;
        idx = 32'h0000_0000;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = 32'(i);
            end
        end
        low_index = idx;
    endfunction

    // Per-nibble digit check and add-three adjust
    genvar g;
    generate
        for (g = 0; g < NIB; g++) begin : g_nib
            assign nib_bad[g] = (acc_q[4*g+3:4*g] > 4'h9);
            assign dabble_adj[4*g+3:4*g] =
                (work_q[4*g+3:4*g] > 4'h4) ?
                work_q[4*g+3:4*g] + 4'h3 : work_q[4*g+3:4*g];
        end
    endgenerate

    // Decimal weight step of the BCD-to-binary walk
    assign times_ten = (work_q << 3) + (work_q << 1);

    // Next accumulator value and which flags it updates
    always_comb begin
        acc_next = acc_q;
        acc_load = 1'b0;
        flags_zn = 1'b0;
        if (start) begin
            unique case (op)
                abu_pkg::ABU_SHIFT_RIGHT_OP: begin
                    // Counts of 32 and above empty the word
                    acc_next = acc_q >> cnt;
                    acc_load = 1'b1;
                    flags_zn = 1'b1;
                end
                abu_pkg::ABU_ROTATE_LEFT_OP: begin
                    acc_next = rotate_left_op(acc_q, cnt);
                    acc_load = 1'b1;
                    flags_zn = 1'b1;
                end
                abu_pkg::ABU_ROTATE_RIGHT_OP: begin
                    // Right by n equals left by 32 - n
                    acc_next = rotate_left_op(acc_q,
                        6'd32 - {1'b0, cnt[4:0]});
                    acc_load = 1'b1;
                    flags_zn = 1'b1;
                end
                abu_pkg::ABU_LOWEST_SET_BIT_INDEX_OP: begin
                    // Lowest set bit wins; an empty word gives zero
                    acc_next = low_index(acc_q);
                    acc_load = 1'b1;
                end
                abu_pkg::ABU_ONE_HOT_EXPAND_OP: begin
                    // Only the low five index bits choose the bit
                    acc_next = 32'h0000_0001
                        << acc_q[4:0];
                    acc_load = 1'b1;
                end
                abu_pkg::ABU_ONES_COMPLEMENT_OP: begin
                    acc_next = ~acc_q;
                    acc_load = 1'b1;
                end
                default: begin
                    acc_next = acc_q;
                end
            endcase
        end else if (wr_en && hit_acc && state_q == abu_pkg::ABU_IDLE
                     && addr[ADDR_W-1:5] == '0) begin
            // Software load, refused while a conversion runs
            acc_next = wr_data;
            acc_load = 1'b1;
        end else if (state_q == abu_pkg::ABU_TO_BCD
                     && step_q == 6'h01) begin
            // Last dabble step lands straight in the accumulator
            acc_next = {dabble_adj[30:0], src_q[31]};
            acc_load = 1'b1;
            flags_zn = 1'b1;
        end else if (state_q == abu_pkg::ABU_FROM_BCD
                     && step_q == 6'h01) begin
            // Last digit lands straight in the accumulator
            acc_next = times_ten + {28'h0000000, src_q[31:28]};
            acc_load = 1'b1;
            flags_zn = 1'b1;
        end
    end

    // Accumulator register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= `ABU_ACC_RST;
        end else if (acc_load) begin
            acc_q <= acc_next;
        end
    end

    // Multi-cycle conversion sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= abu_pkg::ABU_IDLE;
            step_q <= 6'h00;
            work_q <= 32'h0000_0000;
            src_q <= 32'h0000_0000;
            busy_q <= 1'b0;
        end else begin
            unique case (state_q)
                abu_pkg::ABU_IDLE: begin
                    // Capture the operand and arm the step counter
                    if (start && op == abu_pkg::ABU_RADIX2_TO_BCD_OP) begin
                        state_q <= abu_pkg::ABU_TO_BCD;
                        busy_q <= 1'b1;
                        step_q <= `ABU_B2D_STEPS;
                        work_q <= 32'h0000_0000;
                        src_q <= acc_q;
                    end else if (start &&
                                 op == abu_pkg::ABU_BCD_TO_RADIX2_OP) begin
                        state_q <= abu_pkg::ABU_FROM_BCD;
                        busy_q <= 1'b1;
                        step_q <= `ABU_D2B_STEPS;
                        work_q <= 32'h0000_0000;
                        src_q <= acc_q;
                    end
                end
                abu_pkg::ABU_TO_BCD: begin
                    // Double dabble, digits above eight are dropped
                    work_q <= {dabble_adj[30:0], src_q[31]};
                    src_q <= src_q << 1;
                    step_q <= step_q - 6'h01;
                    if (step_q == 6'h01) begin
                        state_q <= abu_pkg::ABU_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                abu_pkg::ABU_FROM_BCD: begin
                    // Most significant digit first, times ten plus digit
                    work_q <= times_ten
                        + {28'h0000000, src_q[31:28]};
                    src_q <= src_q << 4;
                    step_q <= step_q - 6'h01;
                    if (step_q == 6'h01) begin
                        state_q <= abu_pkg::ABU_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    // Unused state code falls back to idle
                    state_q <= abu_pkg::ABU_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Zero and negative flags, held between updating operations
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (flags_zn) begin
            zero_q <= (acc_next == 32'h0000_0000);
            neg_q <= acc_next[31];
        end
    end

    // Operand-range flag, touched only by encode
    // Several set bits leave the index ambiguous
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            range_q <= 1'b0;
        end else if (start &&
                     op == abu_pkg::ABU_LOWEST_SET_BIT_INDEX_OP) begin
            range_q <= ((acc_q & (acc_q - 32'h0000_0001))
                        != 32'h0000_0000);
        end
    end

    // Invalid-BCD flag, sampled at the start of BCD-to-binary
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            badbcd_q <= 1'b0;
        end else if (start && op == abu_pkg::ABU_BCD_TO_RADIX2_OP) begin
            badbcd_q <= |nib_bad;
        end
    end

    // Interrupt events: completion, range and bad digit
    assign done_ev = (start && acc_load) || (state_q !=
        abu_pkg::ABU_IDLE && step_q == 6'h01);
    assign range_ev = start && op ==
        abu_pkg::ABU_LOWEST_SET_BIT_INDEX_OP &&
        ((acc_q & (acc_q - 32'h0000_0001)) != 32'h0000_0000);
    assign bad_ev = start && op == abu_pkg::ABU_BCD_TO_RADIX2_OP &&
        (|nib_bad);
    // Gather the events in status bit order
    always_comb begin
        ev = 3'h0;
        ev[`ABU_INT_DONE] = done_ev;
        ev[`ABU_INT_RANGE] = range_ev;
        ev[`ABU_INT_BADBCD] = bad_ev;
    end

    // Sticky status; a new event wins over a clear
    // Only bits written as one are cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_stat_q <= 3'h0;
        end else if (wr_en && hit_clr && addr[ADDR_W-1:5] == '0) begin
            int_stat_q <= (int_stat_q & ~wr_data[2:0]) | ev;
        end else begin
            int_stat_q <= int_stat_q | ev;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_en_q <= `ABU_INT_EN_RST;
        end else if (wr_en && hit_en && addr[ADDR_W-1:5] == '0) begin
            int_en_q <= wr_data[2:0];
        end
    end

    // Level interrupt, one cycle behind the status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_en_q);
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 32'h0000_0000;
        end else if (rd_en && addr[ADDR_W-1:5] == '0) begin
            unique case (a8)
                `ABU_OFF_ACC: rd_data_q <= acc_q;
                `ABU_OFF_CMD: rd_data_q <= {31'h0, state_q !=
                                             abu_pkg::ABU_IDLE};
                `ABU_OFF_FLAGS: rd_data_q <= {28'h0000000, badbcd_q,
                                               range_q, neg_q, zero_q};
                `ABU_OFF_INT_STAT: rd_data_q <= {29'h0, int_stat_q};
                `ABU_OFF_INT_EN: rd_data_q <= {29'h0, int_en_q};
                // Write-only and unused offsets read as zero
                default: rd_data_q <= 32'h0000_0000;
            endcase
        end else begin
            rd_data_q <= 32'h0000_0000;
        end
    end

    // Outputs straight from their registers
    assign rd_data = rd_data_q;
    assign busy = busy_q;
    assign zero_result_flag = zero_q;
    assign negative_result_flag = neg_q;
    assign operand_range_flag = range_q;
    assign invalid_bcd_flag = badbcd_q;
    assign irq = irq_q;

endmodule

/* abu_unit_properties.sv */
// Port-level checks for the accumulator unit
`timescale 1ns/100ps
module abu_unit_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic busy,
    input wire logic zero_result_flag,
    input wire logic negative_result_flag,
    input wire logic operand_range_flag,
    input wire logic invalid_bcd_flag,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Command write taken while idle
    wire cmd = wr_en && addr == 8'h04 && !busy;
    wire [3:0] op = wr_data[3:0];
    wire [3:0] flg = {invalid_bcd_flag, operand_range_flag,
        negative_result_flag, zero_result_flag};
    // Accumulator zero state from the last software load
    logic shadow_ok_q;
    logic shadow_zero_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_ok_q <= 1'b0;
            shadow_zero_q <= 1'b0;
        end else if (wr_en && addr == 8'h00 && !busy) begin
            shadow_ok_q <= 1'b1;
            shadow_zero_q <= (wr_data == 32'h0000_0000);
        end else if (wr_en && addr == 8'h04 && !busy) begin
            shadow_ok_q <= 1'b0;
        end
    end
    property p_flag_hold;
        !busy && !(wr_en && addr == 8'h04) |=> $stable(flg);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flags moved with no operation");
    property p_keep;
        cmd && (op == 4'h5 || op == 4'h8) |=> $stable(flg);
    endproperty
    a_keep: assert property (p_keep)
        else $error("decode or invert touched flags");
    property p_enc;
        cmd && op == 4'h4 |=> $stable({flg[3], flg[1:0]});
    endproperty
    a_enc: assert property (p_enc)
        else $error("encode touched other flags");
    property p_shr_neg;
        cmd && op == 4'h1 && wr_data[13:8] != 6'h0
            |=> !negative_result_flag;
    endproperty
    a_shr_neg: assert property (p_shr_neg)
        else $error("shift right left sign set");
    property p_shr_all;
        cmd && op == 4'h1 && wr_data[13:8] == 6'h20 |=> zero_result_flag;
    endproperty
    a_shr_all: assert property (p_shr_all)
        else $error("full shift not zero");
    property p_b2d;
        cmd && op == 4'h7 |=> busy [*8] ##24 busy ##1 !busy;
    endproperty
    a_b2d: assert property (p_b2d)
        else $error("binary to bcd length wrong");
    property p_d2b;
        cmd && op == 4'h6 |=> busy [*8] ##1 !busy;
    endproperty
    a_d2b: assert property (p_d2b)
        else $error("bcd to binary length wrong");
    property p_zn;
        shadow_ok_q && cmd && op inside {4'h2, 4'h3}
            |=> zero_result_flag == $past(shadow_zero_q);
    endproperty
    a_zn: assert property (p_zn)
        else $error("rotate gave wrong zero flag");
    // Main scenarios reached
    c_b2d: cover property (cmd && op == 4'h7);
    c_range: cover property (operand_range_flag);
    c_bad: cover property (invalid_bcd_flag);
endmodule

/* abu_unit_tb.sv */
// Self-checking bench for the accumulator unit
`timescale 1ns/100ps
module abu_unit_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data;
    logic wr_en, rd_en, busy, zf, nf, rf, bf, irq;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] s = 32'h5F;
    logic [3:0] ef = 4'h0;
    logic ie = 1'b1;
    logic [31:0] cor [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0099_0017};
    always #25 clk = ~clk;
    abu_unit i_dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy),
        .zero_result_flag(zf), .negative_result_flag(nf),
        .operand_range_flag(rf), .invalid_bcd_flag(bf), .irq(irq));
    abu_seq_model i_seq (.clk(clk), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
    // Xorshift source
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Expected accumulator after one operation
    function automatic logic [31:0] model(input logic [3:0] op,
        input logic [31:0] a, input logic [5:0] c);
        logic [31:0] r, v;
        logic [4:0] k;
        r = 32'h0;
        k = c[4:0];
        v = a % 32'h5F5_E100;
        case (op)
            4'h1: r = c[5] ? 32'h0 : a >> k;
            4'h2: r = (a << k) | (a >> (6'h20 - k));
            4'h3: r = (a >> k) | (a << (6'h20 - k));
            4'h4: for (int i = 31; i >= 0; i--) if (a[i]) r = 32'(i);
            4'h5: r = 32'h1 << a[4:0];
            4'h6: for (int i = 7; i >= 0; i--) r = r * 32'hA + a[4*i +: 4];
            4'h7: for (int i = 0; i < 8; i++) begin
                r[4*i +: 4] = 4'(v % 32'hA);
                v = v / 32'hA;
            end
            4'h8: r = ~a;
            default: r = a;
        endcase
        return r;
    endfunction
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Load, run, read back result, flags and events
    task automatic run(input logic [3:0] op, input logic [31:0] a,
        input logic [5:0] c);
        logic [31:0] e, g;
        logic m, bv;
        e = model(op, a, c);
        m = op == 4'h4 && $countones(a) > 1;
        bv = 1'b0;
        for (int i = 0; i < 8; i++) if (a[4*i +: 4] > 4'h9) bv = op == 4'h6;
        if (op == 4'h4) ef[2] = m;
        if (op == 4'h6) ef[3] = bv;
        if (op inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7})
            ef[1:0] = {e[31], e == 32'h0};
        i_seq.wr(8'h00, a);
        i_seq.cmd(op, c);
        if (op == 4'h7) i_seq.wr(8'h00, 32'h5A5A_5A5A);
        @(negedge clk);
        for (int n = 0; n < 40 && busy; n++) @(negedge clk);
        chk({31'h0, busy}, 32'h0);
        i_seq.rd(8'h00, g);
        chk(g, e);
        i_seq.rd(8'h08, g);
        chk(g, {28'h0, ef});
        chk({28'h0, bf, rf, nf, zf}, {28'h0, ef});
        i_seq.rd(8'h0C, g);
        chk(g, {29'h0, bv, m, 1'b1});
        chk({31'h0, irq}, {31'h0, ie});
        i_seq.wr(8'h10, 32'h7);
        i_seq.rd(8'h0C, g);
        chk(g, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [31:0] g;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        i_seq.rd(8'h00, g);
        chk(g, 32'h0);
        i_seq.rd(8'h14, g);
        chk(g, 32'h0);
        i_seq.wr(8'h14, 32'h1);
        for (int i = 0; i < 64; i++)
            run(4'(i % 8 + 1), (i < 32) ? cor[i / 8] : rnd(),
                (i % 3 == 0) ? 6'h20 : 6'(rnd() % 32 + 1));
        i_seq.rd(8'h20, g);
        chk(g, 32'h0);
        i_seq.wr(8'h00, 32'hC3);
        i_seq.wr(8'h40, 32'hFF);
        i_seq.cmd(4'hF, 6'h01);
        i_seq.rd(8'h00, g);
        chk(g, 32'hC3);
        i_seq.rd(8'h0C, g);
        chk(g, 32'h0);
        ie = 1'b0;
        i_seq.wr(8'h14, 32'h0);
        run(4'h8, rnd(), 6'h1);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        i_seq.rd(8'h00, g);
        chk(g, 32'h0);
        chk({28'h0, bf, rf, nf, zf}, 32'h0);
        i_seq.rd(8'h14, g);
        chk(g, 32'h0);
        conclude();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
bind abu_unit abu_unit_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .busy(busy), .zero_result_flag(zero_result_flag),
    .negative_result_flag(negative_result_flag),
    .operand_range_flag(operand_range_flag),
    .invalid_bcd_flag(invalid_bcd_flag), .irq(irq));
